/* pkg/bp_trace_params.svh */
// Purpose: Constants for the breakpoint/trace/timing counter block.
// Assumes: One 100 MHz clock; counters loaded by a setup strobe.
// Notes: Widths are module parameters; these are limits, reset values and the timer tick period.
//
// Contract
// - Trace sample counter adds one per saved sample, stopping at 7FF.
// - Event counter subtracts one per breakpoint event while above zero.
// - Event counter reaching zero starts the post-event delay phase, or halts at once if the delay count is zero.
// - In delay phase, delay counter subtracts one per trace sample while above zero.
// - Delay counter reaching zero halts the emulated processor.
// - While events remain, delay counter keeps its programmed value.
// - Sequence counter subtracts one per finished sequence; count and state readable.
// - Elapsed time resolves to two clock periods, rounded up.
// - Timer clear discards both timers' totals.
// - A timer that is not enabled reads back as zero.
// - Timer 1 also counts its starts for averaging.
`ifndef BP_TRACE_PARAMS_SVH
`define BP_TRACE_PARAMS_SVH
`define TRACE_CNT_MAX 11'h7FF
`define TRACE_CNT_RST 11'h000
`define SETUP_CNT_RST 16'h0000
`define TIMER_TICK_PERIODS 2
`endif

/* pkg/bp_trace_pkg.sv */
// Purpose: Types for the breakpoint/trace/timing counter block.
// Assumes: Nothing beyond the params header.
// Notes: State is visible to monitor software.
package bp_trace_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_EVENTS, ST_DELAY, ST_HALTED} unit_state_e;
  typedef struct packed {
    logic [15:0] events;
    logic [15:0] delays;
    logic [15:0] sequences;
  } setup_s;
endpackage

/* design/bp_trace_counters.sv */
// Purpose: Trace, event, delay and sequence counters plus two elapsed timers.
// Assumes: Qualifying strobes are one-cycle pulses synchronous to sys_clk.
// Notes: Timers count in ticks of two clock periods.
`timescale 1ns/10ps
`include "bp_trace_params.svh"
module bp_trace_counters #(
  parameter int TRACE_W = 11,
  parameter int TIMER_W = 40,
  parameter int STARTS_W = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Setup
  input wire logic setupLoad,
  input wire bp_trace_pkg::setup_s setupVal,
  input wire logic traceReset,
  // Bus cycle events
  input wire logic traceSample,
  input wire logic bpEvent,
  input wire logic seqDone,
  // Timers
  input wire logic timerClear,
  input wire logic timer1En,
  input wire logic timer2En,
  input wire logic timer1Run,
  input wire logic timer2Run,
  // Status
  output logic [TRACE_W-1:0] traceCount,
  output logic [15:0] eventsLeft,
  output logic [15:0] delaysLeft,
  output logic [15:0] seqCount,
  output bp_trace_pkg::unit_state_e unitState,
  output logic haltReq,
  output logic [TIMER_W-1:0] timer1Total,
  output logic [TIMER_W-1:0] timer2Total,
  output logic [STARTS_W-1:0] timer1Starts
);
  import bp_trace_pkg::*;

  // Both timers share one bookkeeping scheme, built once per timer below
  localparam int TIMERS = 2;
  localparam int PHASE_W = (`TIMER_TICK_PERIODS > 1) ? $clog2(`TIMER_TICK_PERIODS) : 1;
  localparam logic [PHASE_W-1:0] PHASE_LAST = PHASE_W'(`TIMER_TICK_PERIODS - 1);

  // Trace sample counter
  logic [TRACE_W-1:0] trace_ff;
  logic [TRACE_W-1:0] nxt_trace;

  // Breakpoint event, post-event delay and sequence counters
  logic [15:0] events_ff;
  logic [15:0] nxt_events;
  logic [15:0] delays_ff;
  logic [15:0] nxt_delays;
  logic [15:0] seq_ff;
  logic [15:0] nxt_seq;

  // Operating state and halt request
  unit_state_e state_ff;
  unit_state_e nxt_state;
  logic halt_ff;
  logic nxt_halt;

  // Start counting for timer 1
  logic run1Prev_ff;
  logic [STARTS_W-1:0] starts_ff;
  logic [STARTS_W-1:0] nxt_starts;

  // Trace counter decode
  wire traceFull = (trace_ff == TRACE_W'(`TRACE_CNT_MAX));
  wire traceStep = traceSample && !traceFull;

  // Saturating rather than wrapping lets software tell the buffer has rolled over;
  // a trace reset beats a sample arriving in the same cycle
  assign nxt_trace = traceReset ? TRACE_W'(`TRACE_CNT_RST) :
                     traceStep ? trace_ff + TRACE_W'(1) : trace_ff;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      trace_ff <= TRACE_W'(`TRACE_CNT_RST);
    end else begin
      trace_ff <= nxt_trace;
    end
  end

  // Counter decode; a counter at zero ignores its strobe, so none can wrap
  wire eventHit = bpEvent && (events_ff != 16'h0000);
  wire delayPhase = (state_ff == ST_DELAY);
  wire delayHit = delayPhase && traceSample && (delays_ff != 16'h0000);
  wire seqHit = seqDone && (seq_ff != 16'h0000);
  wire evReachZero = eventHit && (events_ff == 16'h0001);
  wire dlReachZero = delayHit && (delays_ff == 16'h0001);
  wire delaysEmpty = (delays_ff == 16'h0000);
  wire loadNoEvents = (setupVal.events == 16'h0000);
  wire loadNoDelays = (setupVal.delays == 16'h0000);

  // A setup load beats any strobe arriving in the same cycle
  assign nxt_events = setupLoad ? setupVal.events :
                      eventHit ? events_ff - 16'h0001 : events_ff;

  // Samples outside the delay phase leave the programmed delay alone
  assign nxt_delays = setupLoad ? setupVal.delays :
                      delayHit ? delays_ff - 16'h0001 : delays_ff;

  assign nxt_seq = setupLoad ? setupVal.sequences :
                   seqHit ? seq_ff - 16'h0001 : seq_ff;

  // Phase sequencing: events, then delay samples, then halt.
  // Halt stays up until the next setup load; nothing else lowers it.
  always_comb begin
    nxt_state = state_ff;
    nxt_halt = halt_ff;
    if (setupLoad) begin
      // Zero counts skip their phase; both zero means halt at once
      if (!loadNoEvents) begin
        nxt_state = ST_EVENTS;
      end else if (!loadNoDelays) begin
        nxt_state = ST_DELAY;
      end else begin
        nxt_state = ST_HALTED;
      end
      nxt_halt = loadNoEvents && loadNoDelays;
    end else begin
      case (state_ff)
        ST_EVENTS: begin
          if (evReachZero) begin
            nxt_state = delaysEmpty ? ST_HALTED : ST_DELAY;
            nxt_halt = delaysEmpty;
          end
        end
        ST_DELAY: begin
          if (dlReachZero || delaysEmpty) begin
            nxt_state = ST_HALTED;
            nxt_halt = 1'b1;
          end
        end
        default: begin
          nxt_state = state_ff;
        end
      endcase
    end
  end

  // Registers only; every next value is decoded above
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      events_ff <= `SETUP_CNT_RST;
      delays_ff <= `SETUP_CNT_RST;
      seq_ff <= `SETUP_CNT_RST;
      state_ff <= ST_IDLE;
      halt_ff <= 1'b0;
    end else begin
      events_ff <= nxt_events;
      delays_ff <= nxt_delays;
      seq_ff <= nxt_seq;
      state_ff <= nxt_state;
      halt_ff <= nxt_halt;
    end
  end

  // Timer inputs gathered per timer, timer 1 in bit 0
  wire [TIMERS-1:0] timerEn = {timer2En, timer1En};
  wire [TIMERS-1:0] timerRun = {timer2Run, timer1Run};
  wire [TIMER_W-1:0] timerShown [TIMERS];

  // Each timer keeps its own tick phase, restarted on every run, so a run of
  // N clocks adds N/2 ticks rounded up whatever phase a shared divider had.
  // The phase follows the run level only, so enabling a running timer
  // picks up the tick period already under way.
  genvar gi;
  generate
    for (gi = 0; gi < TIMERS; gi++) begin : g_timer
      logic [TIMER_W-1:0] total_ff;
      logic [TIMER_W-1:0] nxt_total;
      logic [PHASE_W-1:0] phase_ff;
      logic [PHASE_W-1:0] nxt_phase;
      wire phaseWrap = (phase_ff == PHASE_LAST);
      // Tick enable: one pulse per tick period while the timer runs
      wire tickEn = timerRun[gi] && (phase_ff == PHASE_W'(0));

      assign nxt_phase = !timerRun[gi] ? PHASE_W'(0) :
                         phaseWrap ? PHASE_W'(0) : phase_ff + PHASE_W'(1);

      // The first clock of a run ticks, so a part-used tick counts whole
      assign nxt_total = timerClear ? TIMER_W'(0) :
                         (timerEn[gi] && tickEn) ? total_ff + TIMER_W'(1) : total_ff;

      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          phase_ff <= PHASE_W'(0);
          total_ff <= TIMER_W'(0);
        end else begin
          phase_ff <= nxt_phase;
          total_ff <= nxt_total;
        end
      end

      // A disabled timer reads as zero but keeps its total
      assign timerShown[gi] = timerEn[gi] ? total_ff : TIMER_W'(0);
    end
  endgenerate

  // Timer 1 start count, for software to average over
  wire t1Start = timer1Run && !run1Prev_ff;
  assign nxt_starts = timerClear ? STARTS_W'(0) :
                      (timer1En && t1Start) ? starts_ff + STARTS_W'(1) : starts_ff;

  // Previous run level resets low to match the idle pin, so no false start
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      run1Prev_ff <= 1'b0;
      starts_ff <= STARTS_W'(0);
    end else begin
      run1Prev_ff <= timer1Run;
      starts_ff <= nxt_starts;
    end
  end

  // Status outputs
  assign traceCount = trace_ff;
  assign eventsLeft = events_ff;
  assign delaysLeft = delays_ff;
  assign seqCount = seq_ff;
  assign unitState = state_ff;
  assign haltReq = halt_ff;
  assign timer1Total = timerShown[0];
  assign timer2Total = timerShown[1];
  // Start count belongs to timer 1 and hides with it
  assign timer1Starts = timer1En ? starts_ff : STARTS_W'(0);
endmodule

/* test/bp_bus_model.sv */
// Purpose: Bus cycle strobes of the emulated processor.
// Assumes: Kick is set just after a clock edge.
// Notes: One strobe per kick bit, one cycle per set.
`timescale 1ns/10ps
module bp_bus_model (
  // Requests
  input wire logic [2:0] kick,
  // Strobes
  output logic traceSample,
  output logic bpEvent,
  output logic seqDone
);
  assign {seqDone, bpEvent, traceSample} = kick;
endmodule

/* test/bp_trace_counters_chk.sv */
// Purpose: Port checks of the counter block.
// Assumes: One clock domain.
// Notes: Bound into the block below.
`timescale 1ns/10ps
module bp_trace_counters_chk #(
  parameter int TRACE_W = 11,
  parameter int TIMER_W = 40
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Strobes
  input wire logic setupLoad,
  input wire logic traceReset,
  input wire logic traceSample,
  input wire logic bpEvent,
  input wire logic seqDone,
  input wire logic timerClear,
  // Status
  input wire logic haltReq,
  input wire logic [TRACE_W-1:0] traceCount,
  input wire logic [15:0] eventsLeft,
  input wire logic [15:0] delaysLeft,
  input wire logic [15:0] seqCount,
  input wire bp_trace_pkg::unit_state_e unitState,
  input wire logic [TIMER_W-1:0] timer1Total,
  input wire logic [TIMER_W-1:0] timer2Total
);
  import bp_trace_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  chk_trace_cap: assert property (traceSample && !traceReset && &traceCount |=> &traceCount)
    else $error("trace passed limit");
  chk_event_step: assert property (bpEvent && !setupLoad && eventsLeft != 0 |=>
    eventsLeft == $past(eventsLeft) - 16'h1) else $error("event step");
  chk_delay_phase: assert property (eventsLeft == 0 |-> unitState != ST_EVENTS)
    else $error("no delay phase");
  chk_delay_step: assert property (unitState == ST_DELAY && traceSample && !setupLoad
    && delaysLeft != 0 |=> delaysLeft == $past(delaysLeft) - 16'h1) else $error("delay step");
  chk_halt_zero: assert property (delaysLeft == 0 && eventsLeft == 0 && unitState != ST_IDLE
    |-> haltReq && unitState == ST_HALTED) else $error("no halt");
  chk_delay_hold: assert property (eventsLeft != 0 && !setupLoad |=> $stable(delaysLeft))
    else $error("delay moved");
  chk_seq_step: assert property (seqDone && !setupLoad |=> seqCount ==
    ($past(seqCount) == 0 ? 16'h0 : $past(seqCount) - 16'h1)) else $error("seq step");
  chk_timer_clear: assert property (timerClear |=> (timer1Total | timer2Total) == 0)
    else $error("timer kept");
  cover property (unitState == ST_HALTED);
  cover property (traceSample && &traceCount);
  cover property (timerClear);
  cover property (unitState == ST_DELAY && traceSample);
endmodule
bind bp_trace_counters bp_trace_counters_chk #(
  .TRACE_W(TRACE_W),
  .TIMER_W(TIMER_W)
) u_bp_trace_counters_chk (
  .sys_clk(sys_clk),
  .rst_n(rst_n),
  .setupLoad(setupLoad),
  .traceReset(traceReset),
  .traceSample(traceSample),
  .bpEvent(bpEvent),
  .seqDone(seqDone),
  .timerClear(timerClear),
  .haltReq(haltReq),
  .traceCount(traceCount),
  .eventsLeft(eventsLeft),
  .delaysLeft(delaysLeft),
  .seqCount(seqCount),
  .unitState(unitState),
  .timer1Total(timer1Total),
  .timer2Total(timer2Total)
);

/* test/bp_trace_counters_test.sv */
// Purpose: Directed run of the counter block.
// Assumes: 100 MHz clock.
// Notes: Bus cycle strobes come from the partner model.
`timescale 1ns/10ps
module bp_trace_counters_test;
  import bp_trace_pkg::*;
  logic sys_clk = 0, rst_n = 0, setupLoad = 0, traceReset = 0, timerClear = 0;
  logic timer1En = 0, timer2En = 0, timer1Run = 0, timer2Run = 0, traceSample, bpEvent, seqDone;
  logic [2:0] kick = 3'h0;
  setup_s setupVal = '0;
  logic haltReq;
  logic [10:0] traceCount;
  logic [15:0] eventsLeft, delaysLeft, seqCount, timer1Starts;
  unit_state_e unitState;
  logic [39:0] timer1Total, timer2Total;
  int failures = 0, checked = 0;
  always #5 sys_clk = ~sys_clk;
  bp_trace_counters u_bp_trace_counters (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .setupLoad(setupLoad),
    .setupVal(setupVal),
    .traceReset(traceReset),
    .traceSample(traceSample),
    .bpEvent(bpEvent),
    .seqDone(seqDone),
    .timerClear(timerClear),
    .timer1En(timer1En),
    .timer2En(timer2En),
    .timer1Run(timer1Run),
    .timer2Run(timer2Run),
    .traceCount(traceCount),
    .eventsLeft(eventsLeft),
    .delaysLeft(delaysLeft),
    .seqCount(seqCount),
    .unitState(unitState),
    .haltReq(haltReq),
    .timer1Total(timer1Total),
    .timer2Total(timer2Total),
    .timer1Starts(timer1Starts)
  );
  bp_bus_model u_bp_bus_model (
    .kick(kick),
    .traceSample(traceSample),
    .bpEvent(bpEvent),
    .seqDone(seqDone)
  );
  task cmp(input logic [39:0] g, e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("unexpected %0t: saw %0h expected %0h", $time, g, e);
    end
  endtask
  task act(input logic [2:0] k, input int n);
    repeat (n) @(posedge sys_clk) kick <= k;
    @(posedge sys_clk) kick <= 3'h0;
    @(negedge sys_clk);
  endtask
  task wrap_up;
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk) setupVal <= '{16'h1, 16'h2, 16'h2};
    setupLoad <= 1'b1;
    @(posedge sys_clk) setupLoad <= 1'b0;
    act(3'h1, 1);
    cmp(delaysLeft, 16'h2);
    act(3'h2, 2);
    cmp({unitState, eventsLeft}, {ST_DELAY, 16'h0});
    act(3'h1, 1);
    cmp({haltReq, delaysLeft}, 1);
    act(3'h1, 2);
    cmp({unitState, haltReq, delaysLeft}, {ST_HALTED, 17'h10000});
    act(3'h4, 3);
    cmp(seqCount, 0);
    @(posedge sys_clk) setupVal <= '{16'h0, 16'h1, 16'h0};
    setupLoad <= 1'b1;
    @(posedge sys_clk) setupLoad <= 1'b0;
    @(negedge sys_clk) cmp({unitState, haltReq, delaysLeft}, {ST_DELAY, 17'h00001});
    act(3'h1, 1);
    cmp({unitState, haltReq, delaysLeft}, {ST_HALTED, 17'h10000});
    @(posedge sys_clk) traceReset <= 1'b1;
    @(posedge sys_clk) traceReset <= 1'b0;
    act(3'h1, 2046);
    cmp(traceCount, 11'h7FE);
    act(3'h1, 2);
    cmp(traceCount, 11'h7FF);
    @(posedge sys_clk) {timer1En, timer1Run, timer2En, timer2Run} <= 4'hF;
    repeat (10) @(posedge sys_clk);
    {timer1Run, timer2Run} <= 2'h0;
    @(negedge sys_clk) cmp(timer1Starts, 1);
    cmp(timer1Total, 40'h5);
    cmp(timer2Total, 40'h5);
    @(posedge sys_clk) timer1Run <= 1'b1;
    repeat (3) @(posedge sys_clk);
    timer1Run <= 1'b0;
    @(negedge sys_clk) cmp(timer1Total, 40'h7);
    cmp(timer1Starts, 2);
    @(posedge sys_clk) timer1En <= 1'b0;
    repeat (2) @(negedge sys_clk);
    cmp(timer1Total, 0);
    cmp(timer1Starts, 0);
    cmp(timer2Total, 40'h5);
    @(posedge sys_clk) {timer1En, timerClear} <= 2'h3;
    @(posedge sys_clk) timerClear <= 1'b0;
    @(negedge sys_clk) cmp(timer1Total | timer2Total | timer1Starts, 0);
    wrap_up;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    wrap_up;
  end
endmodule
